/* rtl/lldma_buscyc.sv */
module lldma_buscyc
    import lldma_pkg::*;
(
    input  wire logic          core_clk,
    input  wire logic          rst_n,
    input  wire logic          start,
    input  wire logic          kill,
    input  wire logic          is_wr,
    input  wire logic [AW-1:0] addr,
    input  wire logic [DW-1:0] wdata,
    output logic [AW-1:0]      mem_addr,
    output logic [DW-1:0]      mem_wdata,
    output logic               mem_rd,
    output logic               mem_wr,
    output logic               busy,
    output logic               done
);

    // ========================================================================
    // Fixed three-cycle bus cycle.
    logic          busy_q, busy_d;
    logic [1:0]    cnt_q, cnt_d;
    logic          wr_q, wr_d;
    logic [AW-1:0] addr_q, addr_d;
    logic [DW-1:0] wdata_q, wdata_d;

    assign done      = busy_q && (cnt_q == BUS_LAST);
    assign busy      = busy_q;
    assign mem_rd    = busy_q && !wr_q;
    assign mem_wr    = busy_q && wr_q;
    assign mem_addr  = addr_q;
    assign mem_wdata = wdata_q;

    always_comb begin
        busy_d  = busy_q && !done;
        cnt_d   = busy_q ? 2'(cnt_q + 2'h1) : cnt_q;
        wr_d    = wr_q;
        addr_d  = addr_q;
        wdata_d = wdata_q;
        if (start) begin
            busy_d  = 1'b1;
            cnt_d   = 2'h0;
            wr_d    = is_wr;
            addr_d  = addr;
            wdata_d = wdata;
        end
        if (kill) begin
            busy_d = 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            busy_q  <= 1'b0;
            cnt_q   <= 2'h0;
            wr_q    <= 1'b0;
            addr_q  <= 24'h000000;
            wdata_q <= 16'h0000;
        end else begin
            busy_q  <= busy_d;
            cnt_q   <= cnt_d;
            wr_q    <= wr_d;
            addr_q  <= addr_d;
            wdata_q <= wdata_d;
        end
    end

endmodule : lldma_buscyc

/* rtl/lldma_channel.sv */
// Overview of operation
// - Records sit anywhere; follow each link.
// - Two-bus record: source, destination, count, next.
// - Memory-to-I/O record: source, count, next.
// - I/O-to-memory record: destination, count, next.
// - Each entry 24-bit value plus ignored pad byte.
// - Normal end: count zero and next pointer zero.
// - Terminal-count falling edge aborts when pin-valid set.
// - Clearing enable aborts the chain.
// - Interrupt only on normal end, never abort.
// - Link latch holds next record; registers hold addresses.
// - Count register tracks bytes left in block.
// - Each block: array state then transfer state, or end state if count zero.
// - Array state fetches two bytes per read.
// - Each fetch bus cycle takes three clocks.
// - Acknowledge stays high through array state.
// - Unit per request unless burst set; bus kept three end cycles.
module lldma_channel
    import lldma_pkg::*;
(
    input  wire logic          core_clk,
    input  wire logic          rst_n,
    input  wire logic [2:0]    avs_address,
    input  wire logic          avs_read,
    input  wire logic          avs_write,
    input  wire logic [31:0]   avs_writedata,
    output logic [31:0]        avs_readdata,
    output logic               avs_waitrequest,
    output logic [AW-1:0]      mem_addr,
    output logic [DW-1:0]      mem_wdata,
    output logic               mem_rd,
    output logic               mem_wr,
    input  wire logic [DW-1:0] mem_rdata,
    input  wire logic [DW-1:0] io_data,
    input  wire logic          dma_req,
    input  wire logic          terminal_count_pin,
    output logic               channel_ack_pin_n,
    output logic               bus_hold,
    output logic               irq_req
);

    // ========================================================================
    // State.
    lldma_state_t  state_q, state_d;
    logic [AW-1:0] src_q, src_d;
    logic [AW-1:0] dst_q, dst_d;
    logic [AW-1:0] cnt_q, cnt_d;
    logic [AW-1:0] link_q, link_d;
    logic [AW-1:0] rec_q, rec_d;
    logic [DW-1:0] lo_q, lo_d;
    logic [1:0]    pidx_q, pidx_d;
    logic          half_q, half_d;
    logic [1:0]    endc_q, endc_d;
    logic          en_q, en_d;
    logic          tcv_q, tcv_d;
    logic [1:0]    mode_q, mode_d;
    logic          burst_q, burst_d;
    logic          done_q, done_d;
    logic          abort_q, abort_d;
    logic          irq_q, irq_d;
    logic          ack_q, ack_d;
    logic [31:0]   rdata_q, rdata_d;

    logic          bc_start, bc_kill, bc_wr, bc_busy, bc_done;
    logic [AW-1:0] bc_addr, val;
    logic [DW-1:0] bc_wdata;
    logic          term_fall, active, wr_ctrl, abort_ev, start_ev;
    logic [3:0]    off;

    // ========================================================================
    // Submodules.
    lldma_buscyc u_bus (
        .core_clk  (core_clk),
        .rst_n     (rst_n),
        .start     (bc_start),
        .kill      (bc_kill),
        .is_wr     (bc_wr),
        .addr      (bc_addr),
        .wdata     (bc_wdata),
        .mem_addr  (mem_addr),
        .mem_wdata (mem_wdata),
        .mem_rd    (mem_rd),
        .mem_wr    (mem_wr),
        .busy      (bc_busy),
        .done      (bc_done)
    );

    lldma_fall_det u_term (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .lvl      (terminal_count_pin),
        .fall     (term_fall)
    );

    // ========================================================================
    // Bus slave handshake and outputs.
    assign avs_waitrequest = (avs_read || avs_write) && !ack_q;
    assign avs_readdata    = rdata_q;
    assign active          = (state_q != S_IDLE);
    assign wr_ctrl         = avs_write && ack_q && (avs_address == REG_CTRL);
    assign abort_ev        = active && ((tcv_q && term_fall)
                             || (wr_ctrl && !avs_writedata[CTL_EN]));
    assign start_ev        = !active && wr_ctrl && avs_writedata[CTL_EN];
    assign bus_hold        = active;
    assign irq_req         = irq_q;
    assign channel_ack_pin_n = !(bc_busy && (state_q inside {S_RD, S_WR, S_ONE}));

    // ========================================================================
    // Next-state logic.
    always_comb begin
        state_d  = state_q;
        src_d    = src_q;
        dst_d    = dst_q;
        cnt_d    = cnt_q;
        link_d   = link_q;
        rec_d    = rec_q;
        lo_d     = lo_q;
        pidx_d   = pidx_q;
        half_d   = half_q;
        endc_d   = endc_q;
        en_d     = en_q;
        tcv_d    = tcv_q;
        mode_d   = mode_q;
        burst_d  = burst_q;
        done_d   = done_q;
        abort_d  = abort_q;
        irq_d    = 1'b0;
        ack_d    = (avs_read || avs_write) && !ack_q;
        rdata_d  = rdata_q;
        bc_start = 1'b0;
        bc_kill  = 1'b0;
        bc_wr    = 1'b0;
        bc_addr  = src_q;
        bc_wdata = mem_rdata;
        val      = {mem_rdata[7:0], lo_q};
        off      = {pidx_q, half_q, 1'b0};

        if (ack_d) begin
            unique case (avs_address)
                REG_CTRL: rdata_d = {27'h0, burst_q, mode_q, tcv_q, en_q};
                REG_LINK: rdata_d = {8'h00, link_q};
                REG_STAT: rdata_d = {29'h0, abort_q, done_q, active};
                REG_SRC:  rdata_d = {8'h00, src_q};
                REG_DST:  rdata_d = {8'h00, dst_q};
                REG_CNT:  rdata_d = {8'h00, cnt_q};
                default:  rdata_d = 32'h00000000;
            endcase
        end
        if (wr_ctrl) begin
            en_d  = avs_writedata[CTL_EN];
            tcv_d = avs_writedata[CTL_TCV];
            if (!active) begin
                mode_d  = avs_writedata[CTL_MODE+1:CTL_MODE];
                burst_d = avs_writedata[CTL_BURST];
            end
        end
        if (avs_write && ack_q && !active && avs_address == REG_LINK) begin
            link_d = avs_writedata[AW-1:0];
        end
        if (avs_write && ack_q && avs_address == REG_STAT) begin
            done_d  = done_q && !avs_writedata[ST_DONE];
            abort_d = abort_q && !avs_writedata[ST_ABORT];
        end

        unique case (state_q)
            S_IDLE: begin
                if (start_ev) begin
                    rec_d    = link_q;
                    pidx_d   = 2'h0;
                    half_d   = 1'b0;
                    bc_start = 1'b1;
                    bc_addr  = link_q;
                    state_d  = S_ARRAY;
                end
            end
            S_ARRAY: begin
                if (bc_done && !half_q) begin
                    lo_d     = mem_rdata;
                    half_d   = 1'b1;
                    bc_start = 1'b1;
                    bc_addr  = rec_q + AW'({pidx_q, 2'b10});
                end else if (bc_done) begin
                    half_d = 1'b0;
                    unique case (lldma_fld(mode_q, pidx_q))
                        F_SRC:  src_d  = val;
                        F_DST:  dst_d  = val;
                        F_CNT:  cnt_d  = val;
                        F_NEXT: link_d = val;
                    endcase
                    if (pidx_q == lldma_last(mode_q)) begin
                        endc_d  = 2'h0;
                        state_d = (cnt_q == ZERO_ADDR) ? S_END : S_XFER;
                    end else begin
                        pidx_d   = 2'(pidx_q + 2'h1);
                        bc_start = 1'b1;
                        bc_addr  = rec_q + AW'({2'(pidx_q + 2'h1), 2'b00});
                    end
                end
            end
            S_XFER: begin
                if (burst_q || dma_req) begin
                    bc_start = 1'b1;
                    unique case (mode_q)
                        MODE_TWO:  state_d = S_RD;
                        MODE_M2IO: state_d = S_ONE;
                        default: begin
                            bc_wr    = 1'b1;
                            bc_addr  = dst_q;
                            bc_wdata = io_data;
                            state_d  = S_ONE;
                        end
                    endcase
                end
            end
            S_RD: begin
                if (bc_done) begin
                    bc_start = 1'b1;
                    bc_wr    = 1'b1;
                    bc_addr  = dst_q;
                    state_d  = S_WR;
                end
            end
            S_WR, S_ONE: begin
                if (bc_done) begin
                    src_d   = src_q + UNIT_BYTES;
                    dst_d   = dst_q + UNIT_BYTES;
                    cnt_d   = (cnt_q < UNIT_BYTES) ? ZERO_ADDR : cnt_q - UNIT_BYTES;
                    endc_d  = 2'h0;
                    state_d = (cnt_d == ZERO_ADDR) ? S_END : S_XFER;
                end
            end
            S_END: begin
                endc_d = 2'(endc_q + 2'h1);
                if (endc_q == END_LAST) begin
                    if (link_q == ZERO_ADDR) begin
                        state_d = S_IDLE;
                        irq_d   = 1'b1;
                        done_d  = 1'b1;
                        en_d    = 1'b0;
                    end else begin
                        rec_d    = link_q;
                        pidx_d   = 2'h0;
                        half_d   = 1'b0;
                        bc_start = 1'b1;
                        bc_addr  = link_q;
                        state_d  = S_ARRAY;
                    end
                end
            end
        endcase

        if (abort_ev) begin
            state_d  = S_IDLE;
            bc_start = 1'b0;
            bc_kill  = 1'b1;
            irq_d    = 1'b0;
            abort_d  = 1'b1;
            en_d     = 1'b0;
        end
    end

    // ========================================================================
    // Registers.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= S_IDLE;
            src_q   <= 24'h000000;
            dst_q   <= 24'h000000;
            cnt_q   <= 24'h000000;
            link_q  <= 24'h000000;
            rec_q   <= 24'h000000;
            lo_q    <= 16'h0000;
            pidx_q  <= 2'h0;
            half_q  <= 1'b0;
            endc_q  <= 2'h0;
            en_q    <= 1'b0;
            tcv_q   <= 1'b0;
            mode_q  <= 2'h0;
            burst_q <= 1'b0;
            done_q  <= 1'b0;
            abort_q <= 1'b0;
            irq_q   <= 1'b0;
            ack_q   <= 1'b0;
            rdata_q <= 32'h00000000;
        end else begin
            state_q <= state_d;
            src_q   <= src_d;
            dst_q   <= dst_d;
            cnt_q   <= cnt_d;
            link_q  <= link_d;
            rec_q   <= rec_d;
            lo_q    <= lo_d;
            pidx_q  <= pidx_d;
            half_q  <= half_d;
            endc_q  <= endc_d;
            en_q    <= en_d;
            tcv_q   <= tcv_d;
            mode_q  <= mode_d;
            burst_q <= burst_d;
            done_q  <= done_d;
            abort_q <= abort_d;
            irq_q   <= irq_d;
            ack_q   <= ack_d;
            rdata_q <= rdata_d;
        end
    end

    // ========================================================================
    // Checks.
    fetch_len_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (bc_start && state_d == S_ARRAY && !bc_kill)
        |=> !bc_done ##1 !bc_done ##1 (bc_done || !active))
        else $error("Fetch bus cycle not three clocks.");

    ack_array_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        state_q == S_ARRAY |-> channel_ack_pin_n)
        else $error("Acknowledge low during array state.");

    fetch_addr_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (state_q == S_ARRAY && mem_rd) |-> mem_addr == rec_q + AW'(off))
        else $error("Fetch address off record base.");

    array_xfer_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (state_q == S_ARRAY && bc_done && half_q && pidx_q == lldma_last(mode_q)
         && cnt_q != ZERO_ADDR && !abort_ev) |=> state_q == S_XFER)
        else $error("Array state did not lead to transfer.");

    norm_end_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        irq_req |-> (link_q == ZERO_ADDR && cnt_q == ZERO_ADDR && state_q == S_IDLE))
        else $error("Interrupt without normal end.");

    irq_abort_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        abort_ev |=> !irq_req ##1 !irq_req)
        else $error("Interrupt after abort.");

    term_abort_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (active && tcv_q && $fell(terminal_count_pin)) |=> (state_q == S_IDLE && abort_q))
        else $error("Terminal count edge did not abort.");

    en_abort_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (active && wr_ctrl && !avs_writedata[CTL_EN]) |=> (state_q == S_IDLE && !bus_hold))
        else $error("Enable clear did not abort.");

    end_hold_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (state_q != S_END ##1 state_q == S_END) |-> (bus_hold[*3]))
        else $error("Block end released bus early.");

    relink_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (state_q == S_END && endc_q == END_LAST && link_q != ZERO_ADDR && !abort_ev)
        |=> (state_q == S_ARRAY && rec_q == $past(link_q) && mem_addr == rec_q))
        else $error("Next record not fetched.");

    count_dec_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (state_q inside {S_WR, S_ONE} && bc_done && !abort_ev && cnt_q >= UNIT_BYTES)
        |=> cnt_q == $past(cnt_q) - UNIT_BYTES)
        else $error("Count did not drop by one unit.");

endmodule : lldma_channel

/* rtl/lldma_fall_det.sv */
module lldma_fall_det (
    input  wire logic core_clk,
    input  wire logic rst_n,
    input  wire logic lvl,
    output logic      fall
);

    // ========================================================================
    // High-to-low edge detector.
    logic prev_q, prev_d;

    assign prev_d = lvl;
    assign fall   = prev_q && !lvl;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            prev_q <= 1'b0;
        end else begin
            prev_q <= prev_d;
        end
    end

endmodule : lldma_fall_det

/* rtl/lldma_pkg.sv */
package lldma_pkg;

    // ========================================================================
    // Widths and register map.
    localparam int AW = 24;
    localparam int DW = 16;

    localparam logic [2:0] REG_CTRL = 3'h0;
    localparam logic [2:0] REG_LINK = 3'h1;
    localparam logic [2:0] REG_STAT = 3'h2;
    localparam logic [2:0] REG_SRC  = 3'h3;
    localparam logic [2:0] REG_DST  = 3'h4;
    localparam logic [2:0] REG_CNT  = 3'h5;

    localparam int CTL_EN    = 0;
    localparam int CTL_TCV   = 1;
    localparam int CTL_MODE  = 2;
    localparam int CTL_BURST = 4;

    localparam int ST_BUSY  = 0;
    localparam int ST_DONE  = 1;
    localparam int ST_ABORT = 2;

    // ========================================================================
    // Transfer methods and record fields.
    localparam logic [1:0] MODE_TWO  = 2'h0;
    localparam logic [1:0] MODE_M2IO = 2'h1;
    localparam logic [1:0] MODE_IO2M = 2'h2;

    localparam logic [1:0] F_SRC  = 2'h0;
    localparam logic [1:0] F_DST  = 2'h1;
    localparam logic [1:0] F_CNT  = 2'h2;
    localparam logic [1:0] F_NEXT = 2'h3;

    localparam logic [1:0] LAST_P_TWO = 2'h3;
    localparam logic [1:0] LAST_P_ONE = 2'h2;

    // ========================================================================
    // Timing and steps.
    localparam int         BUS_PHI_CYCLES = 3;
    localparam logic [1:0] BUS_LAST       = 2'(BUS_PHI_CYCLES - 1);
    localparam int         END_CYCLES     = 3;
    localparam logic [1:0] END_LAST       = 2'(END_CYCLES - 1);
    localparam logic [AW-1:0] UNIT_BYTES  = 24'h000002;
    localparam logic [AW-1:0] ZERO_ADDR   = 24'h000000;

    typedef enum logic [2:0] {
        S_IDLE, S_ARRAY, S_XFER, S_RD, S_WR, S_ONE, S_END
    } lldma_state_t;

    // ========================================================================
    // Record field decoding per transfer method.
    function automatic logic [1:0] lldma_fld(input logic [1:0] mode, input logic [1:0] p);
        logic [1:0] f;
        f = p;
        if (mode != MODE_TWO) begin
            unique case (p)
                2'h0:    f = (mode == MODE_M2IO) ? F_SRC : F_DST;
                2'h1:    f = F_CNT;
                default: f = F_NEXT;
            endcase
        end
        return f;
    endfunction : lldma_fld

    function automatic logic [1:0] lldma_last(input logic [1:0] mode);
        return (mode == MODE_TWO) ? LAST_P_TWO : LAST_P_ONE;
    endfunction : lldma_last

endpackage : lldma_pkg

/* sim/lldma_mem_model.sv */
module lldma_mem_model (
    input  wire logic        core_clk,
    input  wire logic [23:0] mem_addr,
    input  wire logic [15:0] mem_wdata,
    input  wire logic        mem_rd,
    input  wire logic        mem_wr,
    output logic [15:0]      mem_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] mem [0:511];
    logic [15:0] last_q = 16'h0000;
    // ========================================================================
    // Memory port.
    // A released bus shows the inverse of the last word, not a stale copy.
    assign mem_rdata = mem_rd ? mem[mem_addr[9:1]] : ~last_q;
    always @(posedge core_clk) begin
        if (mem_rd) begin
            last_q <= mem_rdata;
        end
        if (mem_wr) begin
            mem[mem_addr[9:1]] <= mem_wdata;
        end
    end
endmodule : lldma_mem_model

/* sim/test_lldma_channel.sv */
`define CHK(what, exp, got) begin checked++; if ((got) !== (exp)) begin errors++; \
    $display("ERROR %s exp %0h got %0h", what, exp, got); end end
module test_lldma_channel
    import lldma_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed { logic [1:0] m; logic b; logic [23:0] c; logic [5:0] f; } lldma_row_t;
    logic core_clk = 1'b0, rst_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
    logic [2:0]  avs_address = 3'h0;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, rdv;
    logic avs_waitrequest, mem_rd, mem_wr, channel_ack_pin_n, bus_hold, irq_req;
    logic [23:0] mem_addr;
    logic [15:0] mem_wdata, mem_rdata, ex;
    logic dma_req = 1'b0, terminal_count_pin = 1'b1;
    logic [15:0] io_data = 16'h3C5A;
    int errors = 0, checked = 0, cyc = 0, irqs = 0, fetch = 0, ackbad = 0, n0, ws;
    lldma_row_t rows [5] = '{'{MODE_TWO, 1'b1, 24'h000004, 6'h30},
        '{MODE_TWO, 1'b0, 24'h000006, 6'h30}, '{MODE_M2IO, 1'b1, 24'h000004, 6'h24},
        '{MODE_IO2M, 1'b0, 24'h000002, 6'h24}, '{MODE_TWO, 1'b1, 24'h000000, 6'h30}};
    lldma_channel dut_u (.core_clk(core_clk), .rst_n(rst_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rd(mem_rd), .mem_wr(mem_wr),
        .mem_rdata(mem_rdata), .io_data(io_data), .dma_req(dma_req),
        .terminal_count_pin(terminal_count_pin), .channel_ack_pin_n(channel_ack_pin_n),
        .bus_hold(bus_hold), .irq_req(irq_req));
    lldma_mem_model mem_u (.core_clk(core_clk), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
        .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_rdata(mem_rdata));
    // ========================================================================
    // Clock, monitors and timeout.
    initial begin
        forever #20 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        dma_req <= cyc[2];
        if (irq_req === 1'b1) irqs <= irqs + 1;
        if (mem_rd === 1'b1 && mem_addr < 24'h000100) begin
            fetch <= fetch + 1;
            if (channel_ack_pin_n !== 1'b1) ackbad <= ackbad + 1;
        end
        if (cyc == 20000) begin
            errors++;
            report_and_stop();
        end
    end
    // ========================================================================
    // Tasks.
    function automatic logic [15:0] pat(input int w);
        return {~w[7:0], w[7:0]};
    endfunction : pat
    task automatic bus(input logic wr, input logic [2:0] a, input logic [31:0] d);
        @(posedge core_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= ~wr;
        do begin
            @(posedge core_clk);
        end while (avs_waitrequest !== 1'b0);
        rdv = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask : bus
    task automatic put_rec(input logic [23:0] r, m, s, d, c, n);
        logic [23:0] v [4];
        v = '{s, d, c, n};
        if (m == MODE_M2IO) v = '{s, c, n, n};
        if (m == MODE_IO2M) v = '{d, c, n, n};
        for (int p = 0; p < ((m == MODE_TWO) ? 4 : 3); p++) begin
            mem_u.mem[r[9:1] + 2 * p] = v[p][15:0];
            mem_u.mem[r[9:1] + 2 * p + 1] = {8'hA5, v[p][23:16]};
        end
    endtask : put_rec
    task automatic start(input logic [1:0] m, input logic b, t, input logic [23:0] c);
        for (int w = 128; w < 256; w++) mem_u.mem[w] = (w < 192) ? pat(w) : 16'hDEAD;
        put_rec(24'h000040, m, 24'h000100, 24'h000180, c, 24'h000080);
        put_rec(24'h000080, m, 24'h000140, 24'h0001C0, 24'h000002, 24'h000000);
        fetch = 0;
        bus(1'b1, REG_LINK, 32'h00000040);
        bus(1'b1, REG_CTRL, 32'({b, m, t, 1'b1}));
        repeat (2) @(negedge core_clk);
    endtask : start
    task automatic wait_idle();
        while (bus_hold !== 1'b0) @(negedge core_clk);
    endtask : wait_idle
    task automatic report_and_stop();
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : report_and_stop
    // ========================================================================
    // Main sequence.
    initial begin
        repeat (10) @(posedge core_clk);
        rst_n <= 1'b1;
        @(negedge core_clk);
        `CHK("ack_rst", 1'b1, channel_ack_pin_n)
        `CHK("hold_rst", 1'b0, bus_hold)
        bus(1'b0, 3'h6, 32'h0);
        `CHK("unmapped", 32'h0, rdv)
        bus(1'b1, REG_LINK, 32'hFF123456);
        bus(1'b0, REG_LINK, 32'h0);
        `CHK("link", 32'h00123456, rdv)
        foreach (rows[r]) begin
            n0 = irqs;
            start(rows[r].m, rows[r].b, 1'b0, rows[r].c);
            wait_idle();
            bus(1'b0, REG_STAT, 32'h0);
            `CHK("stat", 32'h2, rdv)
            `CHK("irq", n0 + 1, irqs)
            `CHK("fetch", rows[r].f, fetch)
            `CHK("ack", 0, ackbad)
            bus(1'b0, REG_CNT, 32'h0);
            `CHK("cnt", 32'h0, rdv)
            bus(1'b0, REG_SRC, 32'h0);
            if (rows[r].m != MODE_IO2M) `CHK("src", 32'h142, rdv)
            for (int w = 0; w <= rows[r].c / 2; w++) begin
                ws = (w < rows[r].c / 2) ? 128 + w : 160;
                ex = (rows[r].m == MODE_M2IO) ? 16'hDEAD : io_data;
                if (rows[r].m == MODE_TWO) ex = pat(ws);
                `CHK("data", ex, mem_u.mem[ws + 64])
            end
            bus(1'b1, REG_STAT, 32'h6);
        end
        for (int k = 0; k < 3; k++) begin
            n0 = irqs;
            start(MODE_TWO, 1'b1, k == 0, 24'h000040);
            repeat (40) @(posedge core_clk);
            if (k == 2) bus(1'b1, REG_CTRL, 32'h0);
            else terminal_count_pin <= 1'b0;
            wait_idle();
            bus(1'b0, REG_STAT, 32'h0);
            `CHK("end", (k == 1) ? 32'h2 : 32'h4, rdv)
            `CHK("irq_abort", n0 + (k == 1), irqs)
            bus(1'b1, REG_STAT, 32'h6);
            terminal_count_pin <= 1'b1;
        end
        report_and_stop();
    end
endmodule : test_lldma_channel
